// >>> rtl/host_port.sv
// Host strobe-and-acknowledge access port with device reset and serial output parking
//
// What this block does
// - Direction input: drive data on read only
// - Acknowledge pulled low when transfer completes
// - Acknowledge released to high impedance, never high
// - Reset asserts at once, releases on clock
// - Serial outputs high or off in reset
// - Reset clears handshake state and request registers
// - Local reset-state select chooses later output behaviour
// - 16-bit bidirectional data, bit zero LSB
`timescale 1ns/1ns
module host_port
  import hport_pkg::*;
(
  input  wire logic                          core_clk_in,          // 125 MHz core clock
  input  wire logic                          srst_in,              // Sync reset, active high
  input  wire logic                          dev_reset_n_in,       // Device reset pin, low
  input  wire logic                          port_sel_n_in,        // Port select, low
  input  wire logic                          data_strobe_n_in,     // Data strobe, low
  input  wire logic                          read_not_write_in,    // 1 read, 0 write
  input  wire logic [hport_pkg::ADDR_W-1:0]  host_addr_in,         // Host address
  input  wire logic [hport_pkg::DATA_W-1:0]  host_data_in,         // Data bus, input side
  output logic      [hport_pkg::DATA_W-1:0]  host_data_out,        // Data bus, output side
  output logic                               host_data_oe_out,     // Data bus drive enable
  output logic                               transfer_ack_n_out,   // Acknowledge level
  output logic                               transfer_ack_oe_out,  // Acknowledge drive enable
  output logic                               core_req_valid_out,   // Access pulse to core
  output hport_pkg::host_req_t               core_req_out,         // Access contents
  input  wire logic                          core_rsp_valid_in,    // Core finished access
  input  wire logic [hport_pkg::DATA_W-1:0]  core_rdata_in,        // Core read data
  output logic                               core_in_reset_out,    // Core held in reset
  input  wire logic                          local_out_reset_state,     // Local reset-state pin
  input  wire logic                          backplane_out_reset_state, // Backplane pin
  input  wire logic                          output_drive_enable,       // Drive enable pin
  input  wire logic [31:0]                   local_chan_enable,         // Per-stream enables
  input  wire logic [31:0]                   backplane_chan_enable,     // Per-stream enables
  input  wire logic [31:0]                   local_tx_data_in,     // Local serial bits
  input  wire logic [31:0]                   backplane_tx_data_in, // Backplane serial bits
  output logic      [31:0]                   local_serial_out,     // Local serial data
  output logic      [31:0]                   local_serial_oe_out,  // Local drive enables
  output logic      [31:0]                   backplane_serial_out, // Backplane serial data
  output logic      [31:0]                   backplane_serial_oe_out // Backplane enables
);
  import hport_pkg::*;

  // Reset bridge: pin asserts reset without a clock, release waits two edges
  logic [1:0] rst_pipe_r;
  logic [1:0] rst_pipe_nxt;
  logic       rst_any;

  always_comb begin
    rst_pipe_nxt = {rst_pipe_r[0], 1'b0};
  end

  always_ff @(posedge core_clk_in or negedge dev_reset_n_in) begin
    if (!dev_reset_n_in) begin
      rst_pipe_r <= RST_PIPE_ON;
    end else begin
      rst_pipe_r <= rst_pipe_nxt;
    end
  end

  assign rst_any = rst_pipe_r[1] | srst_in;

  // Host pins pass the three-stage filter; reset parks select and strobe high, direction low
  logic [2:0] pins_q;
  logic [2:0] straps_q;
  logic       sel_q, strobe_q, rnw_q, local_out_reset_state_q, backplane_out_reset_state_q, ode_q;

  pin_sync3 #(
    .WIDTH     (3),
    .RESET_VAL (3'h3)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_any),
    .pin_in      ({read_not_write_in, data_strobe_n_in, port_sel_n_in}),
    .level_out   (pins_q)
  );

  // Straps are never cleared: reset itself must see their true level to park outputs
  pin_sync3 #(
    .WIDTH     (3),
    .RESET_VAL (3'h0)
  ) u_strap_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (1'b0),
    .pin_in      ({output_drive_enable, backplane_out_reset_state, local_out_reset_state}),
    .level_out   (straps_q)
  );

  assign sel_q    = ~pins_q[0];
  assign strobe_q = ~pins_q[1];
  assign rnw_q    = pins_q[2];
  assign local_out_reset_state_q   = straps_q[0];
  assign backplane_out_reset_state_q   = straps_q[1];
  assign ode_q    = straps_q[2];

  // Handshake state
  port_state_t          state_r, state_nxt;
  logic                 ack_oe_r, ack_oe_nxt;
  logic                 data_oe_r, data_oe_nxt;
  logic [DATA_W-1:0]    data_r, data_nxt;
  logic                 req_valid_r, req_valid_nxt;
  host_req_t            req_r, req_nxt;
  logic                 access;

  // An access exists only while select and strobe are both low
  assign access = sel_q & strobe_q;

  always_comb begin
    state_nxt     = state_r;
    ack_oe_nxt    = 1'b0;
    data_oe_nxt   = 1'b0;
    data_nxt      = data_r;
    req_valid_nxt = 1'b0;
    req_nxt       = req_r;
    case (state_r)
      ST_IDLE: begin
        if (access) begin
          // Address and write data have settled by the time the strobe is filtered
          req_valid_nxt = 1'b1;
          req_nxt.write = ~rnw_q;
          req_nxt.addr  = host_addr_in;
          req_nxt.wdata = host_data_in;
          state_nxt     = ST_REQ;
        end
      end
      ST_REQ: begin
        if (!access) begin
          state_nxt = ST_IDLE;                           // Host aborted, no ack given
        end else if (core_rsp_valid_in) begin
          data_nxt    = core_rdata_in;
          ack_oe_nxt  = 1'b1;
          data_oe_nxt = ~req_r.write;
          state_nxt   = ST_ACK;
        end
      end
      ST_ACK: begin
        if (access) begin
          ack_oe_nxt  = 1'b1;
          data_oe_nxt = ~req_r.write;
        end else begin
          state_nxt   = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (rst_any) begin
      state_nxt     = ST_IDLE;
      ack_oe_nxt    = 1'b0;
      data_oe_nxt   = 1'b0;
      req_valid_nxt = 1'b0;
      data_nxt      = DATA_ZERO;
      req_nxt       = REQ_ZERO;
    end
  end

  // Async clear keeps the bus released from the instant the reset pin falls
  always_ff @(posedge core_clk_in or posedge rst_pipe_r[1]) begin
    if (rst_pipe_r[1]) begin
      state_r     <= ST_IDLE;
      ack_oe_r    <= 1'b0;
      data_oe_r   <= 1'b0;
      data_r      <= DATA_ZERO;
      req_valid_r <= 1'b0;
      req_r       <= REQ_ZERO;
    end else begin
      state_r     <= state_nxt;
      ack_oe_r    <= ack_oe_nxt;
      data_oe_r   <= data_oe_nxt;
      data_r      <= data_nxt;
      req_valid_r <= req_valid_nxt;
      req_r       <= req_nxt;
    end
  end

  // Acknowledge only ever drives low; the idle high comes from the board pull-up
  assign transfer_ack_n_out  = 1'b0;
  assign transfer_ack_oe_out = ack_oe_r;
  assign host_data_out       = data_r;
  assign host_data_oe_out    = data_oe_r;
  assign core_req_valid_out  = req_valid_r;
  assign core_req_out        = req_r;

  // Serial output parking
  logic        in_reset_r, in_reset_nxt;
  logic [31:0] lser_r, lser_nxt, loe_r, loe_nxt;
  logic [31:0] bser_r, bser_nxt, boe_r, boe_nxt;
  logic        lfree_r, lfree_nxt, bfree_r, bfree_nxt;

  assign core_in_reset_out   = in_reset_r;

  always_comb begin
    in_reset_nxt = rst_any;
    lser_nxt     = local_tx_data_in;
    bser_nxt     = backplane_tx_data_in;
    lfree_nxt    = lfree_r;
    bfree_nxt    = bfree_r;
    // Strap low: always active; strap high: gated by drive enable and per-stream bits
    loe_nxt = lfree_r ? SER_IDLE : (ode_q ? local_chan_enable : SER_OFF);
    boe_nxt = bfree_r ? SER_IDLE : (ode_q ? backplane_chan_enable : SER_OFF);
    if (in_reset_r) begin
      lser_nxt  = SER_IDLE;
      bser_nxt  = SER_IDLE;
      loe_nxt   = local_out_reset_state_q ? SER_OFF : SER_IDLE;
      boe_nxt   = backplane_out_reset_state_q ? SER_OFF : SER_IDLE;
      lfree_nxt = ~local_out_reset_state_q;
      bfree_nxt = ~backplane_out_reset_state_q;
    end
  end

  // Data is parked high asynchronously; enables follow the straps, which need a running clock
  always_ff @(posedge core_clk_in or posedge rst_pipe_r[1]) begin
    if (rst_pipe_r[1]) begin
      in_reset_r <= 1'b1;
      lser_r     <= SER_IDLE;
      bser_r     <= SER_IDLE;
    end else begin
      in_reset_r <= in_reset_nxt;
      lser_r     <= lser_nxt;
      bser_r     <= bser_nxt;
    end
  end

  always_ff @(posedge core_clk_in) begin
    loe_r   <= loe_nxt;
    boe_r   <= boe_nxt;
    lfree_r <= lfree_nxt;
    bfree_r <= bfree_nxt;
  end

  assign local_serial_out        = lser_r;
  assign local_serial_oe_out     = loe_r;
  assign backplane_serial_out    = bser_r;
  assign backplane_serial_oe_out = boe_r;
endmodule : host_port

// >>> rtl/hport_pkg.sv
// Shared constants, states and request carrier for the host access port
package hport_pkg;
  localparam int unsigned ADDR_W      = 15;    // Host address width
  localparam int unsigned DATA_W      = 16;    // Host data width
  localparam int unsigned STREAMS     = 32;    // Serial outputs per side
  localparam int unsigned CLK_PERIOD_NS = 8;   // Core clock period
  localparam int unsigned ACK_GAP_NS  = 30;    // Host idle time after ack release
  localparam int unsigned ACK_GAP_CYC =
    (ACK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;  // Rounded up, for reference
  localparam logic [1:0]  RST_PIPE_ON  = 2'h3; // Reset bridge value while in reset
  localparam logic [31:0] SER_IDLE     = 32'hffffffff; // Serial outputs parked high
  localparam logic [31:0] SER_OFF      = 32'h00000000; // All enables off
  localparam logic [15:0] DATA_ZERO    = 16'h0000;
  localparam logic [14:0] ADDR_ZERO    = 15'h0000;

  // Handshake states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,  // Waiting for select and strobe
    ST_REQ  = 2'b01,  // Request sent to the core, waiting for its answer
    ST_ACK  = 2'b10   // Acknowledge driven low until the host lets go
  } port_state_t;

  // One host access as handed to the core
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } host_req_t;

  localparam host_req_t REQ_ZERO = '{write: 1'b0, addr: ADDR_ZERO, wdata: DATA_ZERO};
endpackage : hport_pkg

// >>> rtl/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync3 #(
  parameter int unsigned       WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             core_clk_in, // Core clock
  input  wire logic             rst_in,      // Synchronous clear
  input  wire logic [WIDTH-1:0] pin_in,      // Asynchronous pins
  output logic      [WIDTH-1:0] level_out    // Filtered level
);
  logic [WIDTH-1:0] s1_r, s2_r, s3_r, level_r;
  logic [WIDTH-1:0] s1_nxt, s2_nxt, s3_nxt, level_nxt;

  // A bit moves only when stages two and three agree; stage one feeds stage two only
  always_comb begin
    s1_nxt    = pin_in;
    s2_nxt    = s1_r;
    s3_nxt    = s2_r;
    level_nxt = (s2_r & s3_r) | (level_r & (s2_r ^ s3_r));
    if (rst_in) begin
      s1_nxt    = RESET_VAL;
      s2_nxt    = RESET_VAL;
      s3_nxt    = RESET_VAL;
      level_nxt = RESET_VAL;
    end
  end

  always_ff @(posedge core_clk_in) begin
    s1_r    <= s1_nxt;
    s2_r    <= s2_nxt;
    s3_r    <= s3_nxt;
    level_r <= level_nxt;
  end

  assign level_out = level_r;
endmodule : pin_sync3

// >>> verification/async_host_port_handshake_tb_top.sv
// Bench for the host port: host model, stand-in core and reference memory
`timescale 1ns/1ns
module async_host_port_handshake_tb_top;
  import hport_pkg::*;
  logic core_clk_in = 1'h0, srst_in = 1'h1, dev_reset_n_in = 1'h0, core_rsp_valid_in = 1'h0;
  logic local_out_reset_state = 1'h0, backplane_out_reset_state = 1'h1, output_drive_enable = 1'h0;
  logic [31:0] local_chan_enable = '0, backplane_chan_enable = '0;
  logic [31:0] local_tx_data_in = '0, backplane_tx_data_in = '0, seed = 32'h000025b6;
  logic [31:0] local_serial_out, local_serial_oe_out, backplane_serial_out, backplane_serial_oe_out;
  logic port_sel_n_in, data_strobe_n_in, read_not_write_in, host_data_oe_out, transfer_ack_n_out;
  logic transfer_ack_oe_out, core_req_valid_out, core_in_reset_out;
  logic [15:0] core_rdata_in = 16'h0000, host_data_in, host_data_out;
  logic [14:0] host_addr_in, addrs[$];
  host_req_t core_req_out, exp_q[$];
  int num_errors = 0, compares = 0, req_cnt = 0, ref_mem[int];

  host_port host_port_i (.core_clk_in, .srst_in, .dev_reset_n_in, .port_sel_n_in,
    .data_strobe_n_in, .read_not_write_in, .host_addr_in, .host_data_in, .host_data_out,
    .host_data_oe_out, .transfer_ack_n_out, .transfer_ack_oe_out, .core_req_valid_out,
    .core_req_out, .core_rsp_valid_in, .core_rdata_in, .core_in_reset_out,
    .local_out_reset_state, .backplane_out_reset_state, .output_drive_enable,
    .local_chan_enable, .backplane_chan_enable, .local_tx_data_in, .backplane_tx_data_in,
    .local_serial_out, .local_serial_oe_out, .backplane_serial_out, .backplane_serial_oe_out);
  host_cpu_model host_cpu_model_i (.core_clk_in, .ack_oe_in(transfer_ack_oe_out),
    .data_oe_in(host_data_oe_out), .data_drv_in(host_data_out), .sel_n_out(port_sel_n_in),
    .strobe_n_out(data_strobe_n_in), .rnw_out(read_not_write_in), .addr_out(host_addr_in),
    .bus_out(host_data_in));

  always #4 core_clk_in = ~core_clk_in;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    if (num_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // Stand-in core: checks each request, answers after 0 to 3 idle cycles
  always @(posedge core_clk_in) begin : core_stub
    host_req_t e;
    if (core_req_valid_out === 1'h1) begin
      req_cnt++;
      e = exp_q.pop_front();
      chk({core_req_out.write, core_req_out.addr}, {e.write, e.addr});
      if (e.write) chk(core_req_out.wdata, e.wdata);
      repeat (rnd() % 4) @(posedge core_clk_in);
      #1;
      core_rdata_in = e.write ? 16'(rnd()) : 16'(ref_mem[e.addr]);
      core_rsp_valid_in = 1'h1;
      @(posedge core_clk_in);
      #1;
      core_rsp_valid_in = 1'h0;
    end
  end

  // Random accesses; edge addresses written first so every read hits
  task automatic traffic(input int n);
    logic [15:0] rd, wd;
    logic [14:0] a;
    bit ok, rd_op;
    repeat (n) begin
      rd_op = addrs.size() > 2 && rnd() % 2;
      if (rd_op) a = addrs[rnd() % addrs.size()];
      else a = addrs.size() == 0 ? 15'h7fff : addrs.size() == 1 ? 15'h0000 : 15'(rnd());
      wd = 16'(rnd());
      if (!rd_op) ref_mem[a] = wd;
      if (!rd_op) addrs.push_back(a);
      exp_q.push_back('{write: !rd_op, addr: a, wdata: wd});
      host_cpu_model_i.access(rd_op, a, wd, rd, ok);
      chk(ok, 1'h1);
      if (rd_op) chk(rd, ref_mem[a]);
      if (!ok) final_report();
    end
  endtask : traffic

  // Two reset rounds with swapped straps, traffic and lone pins in each
  initial begin
    int i, j;
    logic [31:0] exp_l, exp_b;
    repeat (2) @(posedge core_clk_in);
    #1;
    srst_in = 1'h0;
    for (i = 0; i < 2; i++) begin
      repeat (8) @(posedge core_clk_in);
      #1;
      chk(local_serial_oe_out, i ? SER_OFF : SER_IDLE);
      chk(backplane_serial_oe_out, i ? SER_IDLE : SER_OFF);
      chk(local_serial_out & backplane_serial_out, SER_IDLE);
      dev_reset_n_in = 1'h1;
      repeat (6) @(posedge core_clk_in);
      #1;
      chk(core_in_reset_out, 1'h0);
      traffic(12);
      for (j = 0; j < 2; j++) begin
        repeat (4) @(posedge core_clk_in);
        host_cpu_model_i.pins(j[0], !j[0]);
        repeat (12) @(posedge core_clk_in);
        host_cpu_model_i.pins(1'h1, 1'h1);
      end
      // After reset: data follows the core, enables follow the strap and drive enable
      for (j = 0; j < 2; j++) begin
        @(posedge core_clk_in);
        #1;
        local_tx_data_in = rnd();
        backplane_tx_data_in = rnd();
        local_chan_enable = rnd();
        backplane_chan_enable = rnd();
        output_drive_enable = !j[0];
        exp_l = !local_out_reset_state ? SER_IDLE
              : output_drive_enable ? local_chan_enable : SER_OFF;
        exp_b = !backplane_out_reset_state ? SER_IDLE
              : output_drive_enable ? backplane_chan_enable : SER_OFF;
        repeat (6) @(posedge core_clk_in);
        #1;
        chk(local_serial_out, local_tx_data_in);
        chk(backplane_serial_out, backplane_tx_data_in);
        chk(local_serial_oe_out, exp_l);
        chk(backplane_serial_oe_out, exp_b);
      end
      chk(req_cnt, 12 * (i + 1));
      @(posedge core_clk_in);
      #1;
      local_out_reset_state = 1'h1;
      backplane_out_reset_state = 1'h0;
      dev_reset_n_in = 1'h0;
      #2 chk(core_in_reset_out, 1'h1);
    end
    final_report();
  end
endmodule : async_host_port_handshake_tb_top

// >>> verification/host_cpu_model.sv
// Host processor model: strobe-and-acknowledge master with ack pull-up
`timescale 1ns/1ns
module host_cpu_model
  import hport_pkg::*;
(
  input  wire logic        core_clk_in,           // Core clock
  input  wire logic        ack_oe_in,             // Ack pulled low
  input  wire logic        data_oe_in,            // Device drives bus
  input  wire logic [15:0] data_drv_in,           // Device bus value
  output logic             sel_n_out = 1'h1,      // Port select
  output logic             strobe_n_out = 1'h1,   // Data strobe
  output logic             rnw_out = 1'h1,        // Direction
  output logic [14:0]      addr_out = 15'h0000,   // Address
  output logic [15:0]      bus_out                // Data bus level
);
  logic [15:0] drv = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic        en = 1'h0;
  logic        ack;
  // Pull-up gives the idle high whenever the device lets go
  assign ack = ack_oe_in ? 1'h0 : 1'h1;
  // An undriven bus flips each cycle so a stale value never passes
  assign bus_out = data_oe_in ? data_drv_in : (en ? drv : ~last);
  always @(posedge core_clk_in) last <= bus_out;
  // Select and strobe change just after an edge
  task automatic pins(input logic s, input logic d);
    #1;
    sel_n_out = s;
    strobe_n_out = d;
  endtask : pins
  // One access: idle gap, request held until ack seen low, then release
  task automatic access(input logic rnw, input logic [14:0] a, input logic [15:0] wd,
                        output logic [15:0] rd, output bit ok);
    int n;
    ok = 1'h0;
    repeat (4) @(posedge core_clk_in); // 32ns idle after ack release
    pins(1'h0, 1'h0);
    rnw_out = rnw;
    addr_out = a;
    drv = wd;
    en = !rnw;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge core_clk_in);
      ok = ack === 1'h0;
    end
    rd = bus_out;
    pins(1'h1, 1'h1);
    en = 1'h0;
    for (n = 0; n < 40 && ack !== 1'h1; n++) @(posedge core_clk_in);
    ok = ok && ack === 1'h1;
  endtask : access
endmodule : host_cpu_model

// >>> verification/host_port_checker.sv
// Checks on the host port handshake, device reset and serial parking
`timescale 1ns/1ns
module host_port_checker
  import hport_pkg::*;
(
  input wire logic                 core_clk_in,
  input wire logic                 srst_in,
  input wire logic                 dev_reset_n_in,
  input wire logic                 port_sel_n_in,
  input wire logic                 data_strobe_n_in,
  input wire logic                 core_rsp_valid_in,
  input wire logic                 transfer_ack_n_out,
  input wire logic                 transfer_ack_oe_out,
  input wire logic                 host_data_oe_out,
  input wire hport_pkg::host_req_t core_req_out,
  input wire logic                 core_in_reset_out,
  input wire logic [31:0]          local_serial_out,
  input wire logic [31:0]          backplane_serial_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);
  // Pin filter lags a few edges, so busy and idle spans are eight long
  sequence s_busy;
    !port_sel_n_in && !data_strobe_n_in;
  endsequence
  sequence s_idle;
    port_sel_n_in || data_strobe_n_in;
  endsequence
  a_ack_low_only:
    assert property (transfer_ack_oe_out |-> !transfer_ack_n_out) else $error("ack driven high");
  a_ack_after_rsp:
    assert property ($rose(transfer_ack_oe_out) |-> $past(core_rsp_valid_in))
      else $error("ack before core answer");
  a_ack_idle_bus:
    assert property (s_idle[*8] |-> !transfer_ack_oe_out) else $error("ack on idle bus");
  a_ack_hold:
    assert property (s_busy[*8] ##0 transfer_ack_oe_out |=> transfer_ack_oe_out)
      else $error("ack dropped early");
  a_read_drive_only:
    assert property (host_data_oe_out |-> transfer_ack_oe_out && !core_req_out.write)
      else $error("data driven outside read");
  a_reset_clears:
    assert property (!dev_reset_n_in |-> core_in_reset_out && !transfer_ack_oe_out)
      else $error("reset not applied");
  a_reset_leaves:
    assert property (dev_reset_n_in[*8] |-> !core_in_reset_out) else $error("stuck in reset");
  a_reset_sync:
    assert property ($rose(dev_reset_n_in) |=> core_in_reset_out) else $error("early release");
  a_serial_park:
    assert property (!dev_reset_n_in |-> (local_serial_out & backplane_serial_out) == SER_IDLE)
      else $error("serial not parked");
endmodule : host_port_checker

bind host_port host_port_checker host_port_checker_i (.core_clk_in, .srst_in, .dev_reset_n_in,
  .port_sel_n_in, .data_strobe_n_in, .core_rsp_valid_in, .transfer_ack_n_out,
  .transfer_ack_oe_out, .host_data_oe_out, .core_req_out, .core_in_reset_out,
  .local_serial_out, .backplane_serial_out);
